// ---- rtl/byte_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module byte_fifo
   import spi_rd_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   input  wire logic             flush_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0]   count;
   } fifo_state_type;

   fifo_state_type    st_reg;
   fifo_state_type    st_next;
   logic [WIDTH-1:0]  mem [DEPTH];
   logic              push;
   logic              pop;

   ////////////////////////////////////////////////////////////////////////
   // Handshakes
   assign in_ready_o  = (st_reg.count != (AW+1)'(DEPTH));
   assign out_valid_o = (st_reg.count != '0);
   assign out_data_o  = mem[st_reg.rd_ptr];
   assign push        = in_valid_i & in_ready_o & ~flush_i;
   assign pop         = out_valid_o & out_ready_i & ~flush_i;

   // Pointer and count update
   always_comb
   begin
      st_next = st_reg;
      if (flush_i)
      begin
         st_next = '0;
      end
      else
      begin
         if (push)
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
         if (pop)
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
         if (push && !pop)
            st_next.count = st_reg.count + 1'b1;
         else if (pop && !push)
            st_next.count = st_reg.count - 1'b1;
      end
   end

   // State register and storage
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
      if (push)
         mem[st_reg.wr_ptr] <= in_data_i;
   end
endmodule

// ---- rtl/spi_rd_pkg.sv ----
// Constants shared by the serial register read slave and its byte FIFO.
// Assumes a single 50 MHz system clock; the serial link is oversampled.
package spi_rd_pkg;
   localparam int          SYS_CLK_HZ   = 50000000;
   localparam int          BYTE_BITS    = 8;
   localparam int          ADDR_BITS    = 7;
   localparam int          SYNC_STAGES  = 3;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          RD_FLAG_POS  = 7;          // Read flag in control byte
   localparam logic        RD_FLAG_VAL  = 1'h1;       // Read command value
   localparam logic [2:0]  BIT_LAST     = 3'h7;       // Index of the last bit of a byte
   localparam logic [2:0]  BIT_FIRST    = 3'h0;
   localparam logic [7:0]  ADDR_MSB_SET = 8'h80;      // Full register address top bit
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_CTRL = 4'h2,
      ST_DATA = 4'h4,
      ST_SKIP = 4'h8
   } link_state_type;
endpackage

// ---- rtl/spi_register_read_slave.sv ----
// Serial register read slave: control byte in, auto-incremented bytes out.
// Assumes the link pins are asynchronous to sys_clk_i and the link clock
// is well below a quarter of the system clock. A register source outside
// answers rd_req_o with a byte on rd_data_i and rd_valid_i.
`timescale 1ns/1ns
module spi_register_read_slave
   import spi_rd_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic                 sys_clk_i,
   input  wire logic                 resetn_i,
   input  wire logic                 three_wire_select_i,
   input  wire logic                 csn_i,
   input  wire logic                 sck_i,
   input  wire logic                 sdi_i,
   output logic                      sdi_o,
   output logic                      sdi_oe_o,
   output logic                      sdo_o,
   output logic                      sdo_oe_o,
   output logic                      rd_req_o,
   output logic [BYTE_BITS-1:0]      rd_addr_o,
   input  wire logic                 rd_ready_i,
   input  wire logic [BYTE_BITS-1:0] rd_data_i,
   input  wire logic                 rd_valid_i,
   output logic                      mode11_o,
   output logic                      busy_o
);
   typedef struct packed
   {
      logic [SYNC_STAGES-1:0] csn_sync;
      logic [SYNC_STAGES-1:0] sck_sync;
      logic [SYNC_STAGES-1:0] sdi_sync;
      logic                   csn_q;
      logic                   sck_q;
      logic                   sdi_q;
      link_state_type         state;
      logic                   mode11;
      logic [2:0]             bit_cnt;
      logic [BYTE_BITS-1:0]   shift_in;
      logic [BYTE_BITS-1:0]   shift_out;
      logic [BYTE_BITS-1:0]   addr;
      logic                   req;
      logic                   pending;
      logic                   out_bit;
      logic                   drive;
      logic                   loaded;
   } slave_state_type;

   slave_state_type       st_reg;
   slave_state_type       st_next;
   logic                  csn_fall;
   logic                  csn_rise;
   logic                  sck_rise;
   logic                  sck_fall;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic                  fifo_pop;
   logic [BYTE_BITS-1:0]  fifo_out_data;
   logic [BYTE_BITS-1:0]  out_src;
   logic                  flush;

   // Agreement of the second and third stages counts as a change
   function automatic logic agreed(input logic [SYNC_STAGES-1:0] s);
      return s[1] & s[2];
   endfunction

   function automatic logic agreed_low(input logic [SYNC_STAGES-1:0] s);
      return ~(s[1] | s[2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on filtered pin levels
   assign csn_fall = st_reg.csn_q & agreed_low(st_reg.csn_sync);
   assign csn_rise = ~st_reg.csn_q & agreed(st_reg.csn_sync);
   assign sck_rise = ~st_reg.sck_q & agreed(st_reg.sck_sync) & ~st_reg.csn_q;
   assign sck_fall = st_reg.sck_q & agreed_low(st_reg.sck_sync) & ~st_reg.csn_q;
   assign flush    = csn_rise | (st_reg.state == ST_IDLE);
   assign fifo_pop = (st_reg.state == ST_DATA) && !st_reg.loaded && fifo_out_valid;
   // Byte to shift: the held one, or the FIFO head popped on this very fall
   assign out_src  = st_reg.loaded ? st_reg.shift_out : fifo_out_data;

   // Prefetch FIFO between the register source and the shifter
   byte_fifo #(
      .WIDTH (BYTE_BITS),
      .DEPTH (DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .resetn_i    (resetn_i),
      .flush_i     (flush),
      .in_data_i   (rd_data_i),
      .in_valid_i  (rd_valid_i),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      st_next          = st_reg;
      st_next.csn_sync = {st_reg.csn_sync[SYNC_STAGES-2:0], csn_i};
      st_next.sck_sync = {st_reg.sck_sync[SYNC_STAGES-2:0], sck_i};
      st_next.sdi_sync = {st_reg.sdi_sync[SYNC_STAGES-2:0], sdi_i};
      if (st_reg.csn_sync[1] == st_reg.csn_sync[2])
         st_next.csn_q = st_reg.csn_sync[2];
      if (st_reg.sck_sync[1] == st_reg.sck_sync[2])
         st_next.sck_q = st_reg.sck_sync[2];
      if (st_reg.sdi_sync[1] == st_reg.sdi_sync[2])
         st_next.sdi_q = st_reg.sdi_sync[2];
      // Request handshake with the register source; one request in flight,
      // so a returning byte always finds room in the FIFO
      if (rd_valid_i)
         st_next.pending = 1'b0;
      if (st_reg.req && rd_ready_i)
      begin
         st_next.req     = 1'b0;
         st_next.pending = 1'b1;
         st_next.addr    = st_reg.addr + 1'b1;
      end
      if (st_reg.state == ST_DATA && !st_reg.req && !st_reg.pending && fifo_in_ready)
         st_next.req = 1'b1;
      if (fifo_pop)
      begin
         st_next.shift_out = fifo_out_data;
         st_next.loaded    = 1'b1;
      end
      case (st_reg.state)
         ST_IDLE:
         begin
            st_next.drive   = 1'b0;
            st_next.req     = 1'b0;
            st_next.pending = 1'b0;
            if (csn_fall)
            begin
               st_next.mode11  = st_reg.sck_q;
               st_next.bit_cnt = BIT_FIRST;
               st_next.loaded  = 1'b0;
               st_next.state   = ST_CTRL;
            end
         end
         ST_CTRL:
         begin
            if (sck_rise)
            begin
               st_next.shift_in = {st_reg.shift_in[BYTE_BITS-2:0], st_reg.sdi_q};
               st_next.bit_cnt  = st_reg.bit_cnt + 1'b1;
               if (st_reg.bit_cnt == BIT_LAST)
               begin
                  // Top address bit is restored as one
                  if (st_reg.shift_in[RD_FLAG_POS-1] == RD_FLAG_VAL)
                  begin
                     st_next.addr  = {1'b0, st_reg.shift_in[ADDR_BITS-2:0], st_reg.sdi_q} | ADDR_MSB_SET;
                     st_next.req   = 1'b1;     // First fetch at once, ahead of the first fall
                     st_next.state = ST_DATA;
                  end
                  else
                     st_next.state = ST_SKIP;
               end
            end
         end
         ST_DATA:
         begin
            // Shift out on falling edge, MSB first
            if (sck_fall && (st_reg.loaded || fifo_pop))
            begin
               st_next.drive     = 1'b1;
               st_next.loaded    = 1'b1;
               st_next.out_bit   = out_src[BYTE_BITS-1];
               st_next.shift_out = {out_src[BYTE_BITS-2:0], 1'b0};
            end
            if (sck_rise && st_reg.drive)
            begin
               st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
               if (st_reg.bit_cnt == BIT_LAST)
                  st_next.loaded = 1'b0;
            end
         end
         ST_SKIP:
            st_next.drive = 1'b0;
         default:
            st_next.state = ST_IDLE;
      endcase
      if (csn_rise)
      begin
         st_next.state  = ST_IDLE;
         st_next.drive  = 1'b0;
         st_next.req     = 1'b0;
         st_next.pending = 1'b0;
         st_next.loaded  = 1'b0;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         st_reg           <= '0;
         st_reg.csn_sync  <= '1;
         st_reg.csn_q     <= 1'b1;
         st_reg.state     <= ST_IDLE;
         st_reg.shift_out <= BYTE_ZERO;
      end
      else
         st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers: line choice follows three_wire_select
   assign sdo_o     = st_reg.out_bit;
   assign sdi_o     = st_reg.out_bit;
   assign sdo_oe_o  = st_reg.drive & ~three_wire_select_i;
   assign sdi_oe_o  = st_reg.drive & three_wire_select_i;
   assign rd_req_o  = st_reg.req;
   assign rd_addr_o = st_reg.addr;
   assign mode11_o  = st_reg.mode11;
   assign busy_o    = (st_reg.state != ST_IDLE);
endmodule

// ---- sim/spi_master_model.sv ----
// Serial master model: one control byte out, then read bytes in.
// Assumes the bench resolves the shared line into miso_i.
`timescale 1ns/1ns
module spi_master_model
(
   output logic       csn_o,
   output logic       sck_o,
   output logic       mosi_o,
   output logic       mosi_oe_o,
   input  wire logic  miso_i
);
   logic [7:0] sh;
   logic [7:0] rx [0:31];
   initial
   begin
      csn_o     = 1'b1;
      sck_o     = 1'b0;
      mosi_o    = 1'b0;
      mosi_oe_o = 1'b0;
   end
   // One framed burst; the clock runs only inside the frame
   task automatic burst(input logic m11, input logic [7:0] ctrl, input int n);
      sck_o = m11; // idle level picks the mode
      #320;
      csn_o     = 1'b0;
      mosi_oe_o = 1'b1;
      #80;
      for (int i = 0; i < 8 * (n + 1); i++)
      begin
         sck_o = 1'b0;
         mosi_o = (i < 8) ? ctrl[7 - i] : ~mosi_o; // MSB first, then a toggling pattern
         mosi_oe_o = (i < 8);
         #80;
         sck_o = 1'b1;
         #80;
         sh = {sh[6:0], miso_i};
         if (i % 8 == 7 && i > 8) rx[i / 8 - 1] = sh;
      end
      sck_o = m11;
      #80;
      csn_o = 1'b1;
      #320;
   endtask
endmodule

// ---- sim/spi_register_read_slave_sva.sv ----
// Checker for the serial register read slave, bound to its top ports.
// Assumes three_wire_select_i only changes while the link is idle.
`timescale 1ns/1ns
module spi_register_read_slave_sva
   import spi_rd_pkg::*;
(
   input wire logic                 sys_clk_i,
   input wire logic                 resetn_i,
   input wire logic                 three_wire_select_i,
   input wire logic                 csn_i,
   input wire logic                 sck_i,
   input wire logic                 sdo_o,
   input wire logic                 sdo_oe_o,
   input wire logic                 sdi_oe_o,
   input wire logic                 rd_req_o,
   input wire logic [BYTE_BITS-1:0] rd_addr_o,
   input wire logic                 rd_ready_i,
   input wire logic                 mode11_o,
   input wire logic                 busy_o
);
   logic       sck_d_reg;
   logic       req_seen_reg;
   logic [3:0] fall_age_reg;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // Cycles since the serial clock last fell, saturating; first request of a frame seen
   always_ff @(posedge sys_clk_i)
   begin
      sck_d_reg    <= sck_i;
      req_seen_reg <= resetn_i && busy_o && (req_seen_reg || rd_req_o);
      fall_age_reg <= !resetn_i ? 4'hf : (sck_d_reg && !sck_i) ? 4'h0 : fall_age_reg + {3'h0, fall_age_reg != 4'hf};
   end
   sequence s_accept;
      rd_req_o && rd_ready_i;
   endsequence
   sequence s_stall_selected;
      (!csn_i) [*4] ##0 (rd_req_o && !rd_ready_i);
   endsequence
   chk_sdo_three_wire: assert property (three_wire_select_i |-> !sdo_oe_o)
      else $error("sdo driven in three-wire mode");
   chk_sdi_four_wire: assert property (!three_wire_select_i |-> !sdi_oe_o)
      else $error("shared line driven in four-wire mode");
   chk_csn_release: assert property (csn_i [*6] |-> !busy_o && !sdo_oe_o && !sdi_oe_o)
      else $error("still active after select rose");
   chk_busy_start: assert property ($fell(csn_i) |-> ##[1:6] busy_o)
      else $error("select fall not taken");
   chk_addr_msb: assert property (rd_req_o && !req_seen_reg |-> rd_addr_o[RD_FLAG_POS])
      else $error("address top bit not restored");
   chk_addr_step: assert property (s_accept |=> rd_addr_o == $past(rd_addr_o) + 8'h01)
      else $error("address did not advance by one");
   chk_req_hold: assert property (s_stall_selected |=> rd_req_o && $stable(rd_addr_o))
      else $error("request dropped before accept");
   chk_out_after_fall: assert property (sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |-> fall_age_reg <= 4'h8)
      else $error("output changed away from a clock fall");
   chk_mode_steady: assert property (busy_o [*3] |-> $stable(mode11_o))
      else $error("mode changed inside a transfer");
endmodule
bind spi_register_read_slave spi_register_read_slave_sva u_sva
(
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .three_wire_select_i(three_wire_select_i), .csn_i(csn_i),
   .sck_i(sck_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sdi_oe_o(sdi_oe_o), .rd_req_o(rd_req_o),
   .rd_addr_o(rd_addr_o), .rd_ready_i(rd_ready_i), .mode11_o(mode11_o), .busy_o(busy_o)
);

// ---- sim/spi_register_read_slave_test.sv ----
// Bench for the serial register read slave with a register source model.
// Assumes spi_master_model drives the link at a 160 ns clock.
`timescale 1ns/1ns
module spi_register_read_slave_test;
   logic       sys_clk_i = 1'b0, resetn_i = 1'b0, three_wire_select_i = 1'b0, tog = 1'b0;
   logic       rd_ready_i = 1'b0, rd_valid_i = 1'b0, acc = 1'b0, first = 1'b0, oe_seen = 1'b0;
   logic [7:0] rd_data_i = 8'h00, acc_addr, rd_addr_o;
   logic [7:0] regs [0:255];
   logic       csn, sck, mosi, m_oe, sdi_o, sdi_oe_o, sdo_o, sdo_oe_o, rd_req_o, mode11_o, busy_o;
   wire        sdi_i = sdi_oe_o ? sdi_o : m_oe ? mosi : tog;
   wire        miso = three_wire_select_i ? sdi_i : sdo_oe_o ? sdo_o : tog;
   int         fails = 0, samples_checked = 0, cycles = 0;
   spi_register_read_slave #(.DEPTH(16)) u_dut
   (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .three_wire_select_i(three_wire_select_i), .csn_i(csn),
      .sck_i(sck), .sdi_i(sdi_i), .sdi_o(sdi_o), .sdi_oe_o(sdi_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_ready_i(rd_ready_i), .rd_data_i(rd_data_i),
      .rd_valid_i(rd_valid_i), .mode11_o(mode11_o), .busy_o(busy_o)
   );
   spi_master_model u_master (.csn_o(csn), .sck_o(sck), .mosi_o(mosi), .mosi_oe_o(m_oe), .miso_i(miso));
   initial forever #10 sys_clk_i = ~sys_clk_i;
   // Source bookkeeping, output watch and run limit
   always @(posedge sys_clk_i)
   begin
      acc      <= rd_req_o && rd_ready_i;
      acc_addr <= rd_addr_o;
      if (rd_req_o && rd_ready_i) first <= 1'b0;
      if (sdo_oe_o || sdi_oe_o) oe_seen <= 1'b1;
      cycles++;
      if (cycles == 30000)
      begin
         fails++;
         give_verdict();
      end
   end
   // Source answers each accepted request once; stalls only after the first byte
   always @(negedge sys_clk_i)
   begin
      rd_valid_i = acc;
      rd_data_i  = regs[acc_addr];
      rd_ready_i = first || ($urandom_range(3) != 0);
      tog        = ~tog;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Read flag doubles as the restored top address bit
   function automatic logic [7:0] exp_byte(input logic [7:0] ctrl, input int k);
      return regs[ctrl + 8'(k)];
   endfunction
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic run(input logic tw, input logic m11, input logic [7:0] ctrl, input int n);
      @(negedge sys_clk_i);
      three_wire_select_i = tw;
      first   = 1'b1;
      oe_seen = 1'b0;
      fork
         u_master.burst(m11, ctrl, n);
         begin
            repeat (24) @(negedge sys_clk_i);
            check_bit(mode11_o, m11);
            if (ctrl[7]) check_bit(busy_o, 1'b1);
         end
      join
      for (int k = 0; k < n; k++)
         if (ctrl[7]) check_byte(u_master.rx[k], exp_byte(ctrl, k));
      if (!ctrl[7]) check_bit(oe_seen, 1'b0);
      check_bit(busy_o, 1'b0);
   endtask
   // Corner cases first, then random bursts
   initial
   begin
      void'($urandom(70));
      for (int a = 0; a < 256; a++) regs[a] = 8'($urandom);
      repeat (5) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      run(1'b0, 1'b0, 8'hf6, 2);
      run(1'b1, 1'b1, 8'hf6, 2);
      run(1'b0, 1'b1, 8'h76, 2);
      run(1'b1, 1'b0, 8'h90, 20);
      repeat (8)
         run(1'($urandom_range(1)), 1'($urandom_range(1)),
             8'h80 | 8'($urandom_range(8'h6f)), $urandom_range(4, 1));
      give_verdict();
   end
endmodule
